/* src/ircd_codec.sv */
// Purpose: serial infrared pulse encoder and decoder with avalon register access
// Assumes: pins synchronous to mclk_in; crystal and x16 rates are enable pulses
// Notes: one wait state on every bus access
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
module ircd_codec #(
	parameter int unsigned CRYSTAL_DIV = ircd_pkg::CRYSTAL_DIV,
	parameter int unsigned FIFO_DEPTH = ircd_pkg::TX_FIFO_DEPTH
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic codec_reset_low_in,
	input wire logic clock_source_select_in,
	input wire logic osc_sleep_request_in,
	input wire logic fixed_pulse_select_in,
	input wire logic baud_x16_clock_in,
	input wire logic serial_tx_in,
	input wire logic optical_rx_in,
	output logic optical_tx_out,
	output logic serial_rx_out,
	output logic osc_powered_out,
	output logic tx_accept_out,
	input wire logic [ircd_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);
	localparam int unsigned DW = (CRYSTAL_DIV > 1) ? $clog2(CRYSTAL_DIV) : 1;

	generate
		if (CRYSTAL_DIV < 2 || FIFO_DEPTH < 2)
		begin : g_bad_param
			$error("ircd_codec: CRYSTAL_DIV and FIFO_DEPTH must be at least 2");
		end
	endgenerate

	// ------------------------------------------------------------
	// clock sources
	// ------------------------------------------------------------
	logic codec_hold;
	logic osc_on;
	logic [DW-1:0] div_cnt;
	logic [DW-1:0] next_div_cnt;
	logic half;
	logic next_half;
	logic crystal_tick;
	logic x16_tick;
	logic ext_q;
	logic tx_q;
	logic rx_q;
	logic ext_rise;
	logic tx_fall;
	logic rx_rise;
	logic mono_eff;

	assign codec_hold = !codec_reset_low_in;
	// sleep or external select powers the oscillator down, nothing else
	assign osc_on = !(clock_source_select_in || osc_sleep_request_in);
	assign osc_powered_out = osc_on;
	assign crystal_tick = osc_on && (div_cnt == DW'(CRYSTAL_DIV - 1));
	assign ext_rise = baud_x16_clock_in && !ext_q;
	assign tx_fall = !serial_tx_in && tx_q;
	assign rx_rise = optical_rx_in && !rx_q;
	// select high takes the external clock, low the crystal halved
	assign x16_tick = clock_source_select_in ? ext_rise : (crystal_tick && half);
	// monoshot counts crystal cycles, so it is refused on the external clock
	assign mono_eff = fixed_pulse_select_in && !clock_source_select_in;

	// crystal divider and x16 halving stage
	always_comb
	begin
		next_div_cnt = div_cnt;
		next_half = half;
		if (!osc_on)
		begin
			next_div_cnt = '0;
			next_half = 1'b0;
		end
		else if (crystal_tick)
		begin
			next_div_cnt = '0;
			next_half = !half;
		end
		else
			next_div_cnt = div_cnt + 1'b1;
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_cnt <= '0;
			half <= 1'b0;
			ext_q <= 1'b0;
			tx_q <= 1'b1;
			rx_q <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			half <= next_half;
			ext_q <= baud_x16_clock_in;
			tx_q <= serial_tx_in;
			rx_q <= optical_rx_in;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic overflow;
	logic next_overflow;
	logic [15:0] rx_count;
	logic [15:0] next_rx_count;
	logic ack;
	logic next_ack;
	logic [31:0] next_readdata;
	logic tx_en;
	logic rx_en;
	logic wr_take;
	logic push_drop;
	ircd_pkg::ircd_status_s status;

	ircd_pkg::ircd_cell_e cell_state;
	ircd_pkg::ircd_cell_e next_cell_state;
	ircd_pkg::ircd_pulse_e pulse_state;
	ircd_pkg::ircd_pulse_e next_pulse_state;
	ircd_pkg::ircd_rx_e rx_state;
	ircd_pkg::ircd_rx_e next_rx_state;
	logic [3:0] cell_cnt;
	logic [3:0] next_cell_cnt;
	logic [2:0] pulse_cnt;
	logic [2:0] next_pulse_cnt;
	logic pulse_mono;
	logic next_pulse_mono;
	logic [3:0] rx_cnt;
	logic [3:0] next_rx_cnt;
	logic next_tx_line;
	logic next_rx_line;
	logic fifo_in_valid;
	logic fifo_out_valid;
	logic fifo_pop;
	ircd_pkg::ircd_pulse_req_s fifo_in_word;
	ircd_pkg::ircd_pulse_req_s fifo_out_word;

	assign tx_en = ctrl[ircd_pkg::CTRL_TX_EN_BIT];
	assign rx_en = ctrl[ircd_pkg::CTRL_RX_EN_BIT];
	assign wr_take = avs_write_in && ack;
	assign push_drop = fifo_in_valid && !tx_accept_out;
	// one wait state: request seen, then answered
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
	assign status = '{rx_busy: (rx_state == ircd_pkg::RX_LOW), fifo_empty: !fifo_out_valid,
		overflow: overflow, mono_active: mono_eff, ext_clock: clock_source_select_in,
		osc_running: osc_on};

	// bus slave; unmapped reads give zero, unmapped writes are dropped
	always_comb
	begin
		next_ack = (avs_read_in || avs_write_in) && !ack;
		next_ctrl = ctrl;
		next_overflow = overflow;
		next_readdata = avs_readdata_out;
		if (next_ack)
		begin
			if (avs_address_in == ircd_pkg::REG_CTRL)
				next_readdata = {30'h0, ctrl};
			else if (avs_address_in == ircd_pkg::REG_STATUS)
				next_readdata = {26'h0, status};
			else if (avs_address_in == ircd_pkg::REG_RX_COUNT)
				next_readdata = {16'h0, rx_count};
			else
				next_readdata = 32'h0;
		end
		if (wr_take && avs_byteenable_in[0])
		begin
			if (avs_address_in == ircd_pkg::REG_CTRL)
				next_ctrl = avs_writedata_in[1:0];
			else if (avs_address_in == ircd_pkg::REG_STATUS &&
				avs_writedata_in[ircd_pkg::STATUS_OVERFLOW_BIT])
				next_overflow = 1'b0;
		end
		// a dropped request in the clearing cycle still sets the flag
		if (push_drop)
			next_overflow = 1'b1;
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ack <= 1'b0;
			ctrl <= ircd_pkg::CTRL_RESET;
			overflow <= 1'b0;
			avs_readdata_out <= 32'h0;
		end
		else
		begin
			ack <= next_ack;
			ctrl <= next_ctrl;
			overflow <= next_overflow;
			avs_readdata_out <= next_readdata;
		end
	end

	// ------------------------------------------------------------
	// encoder
	// ------------------------------------------------------------
	ircd_fifo #(
		.WIDTH($bits(ircd_pkg::ircd_pulse_req_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.flush_in(codec_hold),
		.in_valid_in(fifo_in_valid),
		.in_ready_out(tx_accept_out),
		.in_data_in(fifo_in_word),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_out_word)
	);

	// bit cells and pulse generator; a full queue drops and flags
	always_comb
	begin
		next_cell_state = cell_state;
		next_cell_cnt = cell_cnt;
		next_pulse_state = pulse_state;
		next_pulse_cnt = pulse_cnt;
		next_pulse_mono = pulse_mono;
		fifo_in_valid = 1'b0;
		fifo_in_word = '{mono: mono_eff};
		fifo_pop = 1'b0;
		case (cell_state)
			ircd_pkg::CELL_IDLE:
				if (tx_en && tx_fall)
				begin
					fifo_in_valid = 1'b1;
					if (!mono_eff)
					begin
						next_cell_state = ircd_pkg::CELL_RUN;
						next_cell_cnt = 4'h0;
					end
				end
			ircd_pkg::CELL_RUN:
				if (x16_tick)
				begin
					next_cell_cnt = cell_cnt + 4'h1;
					if (cell_cnt == 4'(ircd_pkg::BIT_X16_CYCLES - 1))
					begin
						// another low bit follows: one more pulse
						if (!serial_tx_in && tx_en)
							fifo_in_valid = 1'b1;
						else
							next_cell_state = ircd_pkg::CELL_IDLE;
					end
				end
			default:
				next_cell_state = ircd_pkg::CELL_IDLE;
		endcase
		case (pulse_state)
			ircd_pkg::PULSE_IDLE:
				if (fifo_out_valid)
				begin
					fifo_pop = 1'b1;
					next_pulse_state = ircd_pkg::PULSE_HIGH;
					next_pulse_cnt = 3'h0;
					next_pulse_mono = fifo_out_word.mono;
				end
			ircd_pkg::PULSE_HIGH:
				if (pulse_mono ? crystal_tick : x16_tick)
				begin
					next_pulse_cnt = pulse_cnt + 3'h1;
					if (pulse_mono && pulse_cnt == 3'(ircd_pkg::MONO_CRYSTAL_CYCLES - 1))
						next_pulse_state = ircd_pkg::PULSE_IDLE;
					else if (!pulse_mono && pulse_cnt == 3'(ircd_pkg::PROP_X16_CYCLES - 1))
						next_pulse_state = ircd_pkg::PULSE_IDLE;
				end
			default:
				next_pulse_state = ircd_pkg::PULSE_IDLE;
		endcase
		if (codec_hold)
		begin
			next_cell_state = ircd_pkg::CELL_IDLE;
			next_pulse_state = ircd_pkg::PULSE_IDLE;
			fifo_in_valid = 1'b0;
		end
		next_tx_line = (next_pulse_state == ircd_pkg::PULSE_HIGH);
	end

	// ------------------------------------------------------------
	// decoder
	// ------------------------------------------------------------
	// edge detect accepts either pulse width; a new pulse restarts the bit
	always_comb
	begin
		next_rx_state = rx_state;
		next_rx_cnt = rx_cnt;
		next_rx_count = rx_count;
		// a held codec ignores light entirely, the pulse counter included
		if (rx_en && rx_rise && !codec_hold)
		begin
			next_rx_state = ircd_pkg::RX_LOW;
			next_rx_cnt = 4'h0;
			next_rx_count = rx_count + 16'h1;
		end
		else if (rx_state == ircd_pkg::RX_LOW && x16_tick)
		begin
			next_rx_cnt = rx_cnt + 4'h1;
			if (rx_cnt == 4'(ircd_pkg::BIT_X16_CYCLES - 1))
				next_rx_state = ircd_pkg::RX_IDLE;
		end
		if (codec_hold)
			next_rx_state = ircd_pkg::RX_IDLE;
		next_rx_line = (next_rx_state != ircd_pkg::RX_LOW);
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cell_state <= ircd_pkg::CELL_IDLE;
			cell_cnt <= 4'h0;
			pulse_state <= ircd_pkg::PULSE_IDLE;
			pulse_cnt <= 3'h0;
			pulse_mono <= 1'b0;
			rx_state <= ircd_pkg::RX_IDLE;
			rx_cnt <= 4'h0;
			rx_count <= 16'h0;
			optical_tx_out <= 1'b0;
			serial_rx_out <= 1'b1;
		end
		else
		begin
			cell_state <= next_cell_state;
			cell_cnt <= next_cell_cnt;
			pulse_state <= next_pulse_state;
			pulse_cnt <= next_pulse_cnt;
			pulse_mono <= next_pulse_mono;
			rx_state <= next_rx_state;
			rx_cnt <= next_rx_cnt;
			rx_count <= next_rx_count;
			optical_tx_out <= next_tx_line;
			serial_rx_out <= next_rx_line;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_hold_tx_low: assert property (codec_hold |=> !optical_tx_out)
		else $error("tx pulse while codec held");
	a_hold_rx_high: assert property (codec_hold
		|=> (serial_rx_out && rx_state == ircd_pkg::RX_IDLE))
		else $error("rx line low while codec held");
	a_rx_pulse_low: assert property ((rx_en && rx_rise && !codec_hold) |=> !serial_rx_out)
		else $error("received pulse not decoded");
	a_rx_bit_end: assert property ((rx_state == ircd_pkg::RX_LOW && x16_tick && rx_cnt == 4'hf
		&& !rx_rise && !codec_hold) |=> serial_rx_out)
		else $error("decoded bit not sixteen x16 periods");
	a_mono_end: assert property ((pulse_state == ircd_pkg::PULSE_HIGH && pulse_mono
		&& crystal_tick && pulse_cnt == 3'h5 && !codec_hold) |=> !optical_tx_out)
		else $error("monoshot pulse not six crystal cycles");
	a_mono_stay: assert property ((optical_tx_out && pulse_mono && pulse_cnt < 3'h5
		&& !codec_hold) |=> optical_tx_out)
		else $error("monoshot pulse ended early");
	a_prop_end: assert property ((pulse_state == ircd_pkg::PULSE_HIGH && !pulse_mono
		&& x16_tick && pulse_cnt == 3'h2 && !codec_hold) |=> !optical_tx_out)
		else $error("proportional pulse not three x16 periods");
	a_mono_refused: assert property (clock_source_select_in |-> !mono_eff)
		else $error("monoshot active on external clock");
	a_osc_down: assert property ((clock_source_select_in || osc_sleep_request_in)
		|-> (!osc_powered_out && !crystal_tick))
		else $error("oscillator running while powered down");
	a_ext_tick: assert property (clock_source_select_in |-> (x16_tick == ext_rise))
		else $error("x16 tick not from external rising edge");
	a_edge_sends: assert property ((tx_en && tx_fall && mono_eff && !codec_hold && tx_accept_out
		&& pulse_state == ircd_pkg::PULSE_IDLE && !fifo_out_valid
		&& cell_state == ircd_pkg::CELL_IDLE) ##1 !codec_hold |-> ##1 optical_tx_out)
		else $error("falling edge not modulated");

	c_mono_pulse: cover property ($rose(optical_tx_out) && pulse_mono);
	c_prop_pulse: cover property ($rose(optical_tx_out) && !pulse_mono);
	c_rx_bit: cover property ($rose(serial_rx_out));
	c_fifo_full: cover property (!tx_accept_out);
endmodule : ircd_codec

/* src/ircd_fifo.sv */
// Purpose: small pulse request queue between transmit edge logic and pulse generator
// Assumes: single clock, synchronous flush
// Notes: read data come straight from the storage registers
`timescale 1ns/10ps
module ircd_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 4
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
		begin : g_bad_param
			$error("ircd_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic [PW-1:0] next_wr_ptr;
	logic [PW-1:0] next_rd_ptr;
	logic [PW:0] next_count;
	logic push;
	logic pop;

	// honest full and empty straight from the occupancy count
	assign in_ready_out = (count != (PW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// pointer and count update
	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (flush_in)
		begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end
		else
		begin
			if (push)
				next_wr_ptr = wr_ptr + 1'b1;
			if (pop)
				next_rd_ptr = rd_ptr + 1'b1;
			if (push && !pop)
				next_count = count + 1'b1;
			else if (pop && !push)
				next_count = count - 1'b1;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// storage needs no reset; a word is only read after it was written
	always_ff @(posedge mclk_in)
	begin
		if (push && !flush_in)
			mem[wr_ptr] <= in_data_in;
	end
endmodule : ircd_fifo

/* src/ircd_pkg.sv */
// Purpose: shared constants, register map and carrier types for the infrared pulse codec
// Assumes: one 200 MHz system clock, all pins synchronous to it
// Notes: crystal clock is modelled as a one-cycle enable pulse, the baud clock by rising-edge detection
// Summary of operation
// - low codec reset holds encoder and decoder idle
// - optical pulses of either width are demodulated
// - fixed-pulse select high picks monoshot transmit, on the crystal clock only
// - monoshot pulse ends on the sixth crystal cycle after it starts
// - fixed-pulse select defaults low, proportional mode
// - sleep input stops only the oscillator
// - external clock rising edges, sixteen per bit
// - oscillator off when external clock or sleep
// - clock select high external, low crystal
// - falling transmit edges are modulated onto optical output
// - decoded serial output carries demodulated receive data
package ircd_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned CRYSTAL_HZ = 3686400;
	localparam int unsigned CRYSTAL_DIV = CLK_HZ / CRYSTAL_HZ;
	localparam int unsigned X16_PER_CRYSTAL = 2;
	localparam int unsigned MONO_CRYSTAL_CYCLES = 6;
	localparam int unsigned PROP_X16_CYCLES = 3;
	localparam int unsigned BIT_X16_CYCLES = 16;
	localparam int unsigned TX_FIFO_DEPTH = 4;

	// ------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_RX_COUNT = 4'h8;
	localparam int unsigned CTRL_TX_EN_BIT = 0;
	localparam int unsigned CTRL_RX_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam int unsigned STATUS_OVERFLOW_BIT = 3;

	// ------------------------------------------------------------
	// carriers and states
	// ------------------------------------------------------------
	typedef struct packed {
		logic mono;
	} ircd_pulse_req_s;

	typedef struct packed {
		logic rx_busy;
		logic fifo_empty;
		logic overflow;
		logic mono_active;
		logic ext_clock;
		logic osc_running;
	} ircd_status_s;

	typedef enum logic {CELL_IDLE, CELL_RUN} ircd_cell_e;
	typedef enum logic {PULSE_IDLE, PULSE_HIGH} ircd_pulse_e;
	typedef enum logic {RX_IDLE, RX_LOW} ircd_rx_e;
endpackage : ircd_pkg

/* testbench/ircd_far_end.sv */
// Purpose: far-side model: uart transmit line, x16 baud clock, optical receiver
// Assumes: stepped by the bench through its tasks
// Notes: x16 clock runs free, as a uart baud output does
`timescale 1ns/10ps
module ircd_far_end #(
	parameter int unsigned X16_HALF = 6
) (
	input wire logic mclk_in,
	output logic baud_x16_clock_out,
	output logic serial_tx_out,
	output logic optical_rx_out
);
	int unsigned half_cnt = 0;

	// idle levels: uart line high, no light on the receiver
	initial
	begin
		baud_x16_clock_out = 1'b0;
		serial_tx_out = 1'b1;
		optical_rx_out = 1'b0;
	end

	// free-running x16 clock, so it is there whenever external is selected
	always @(posedge mclk_in)
	begin
		if (half_cnt == X16_HALF - 1)
		begin
			half_cnt <= 0;
			baud_x16_clock_out <= !baud_x16_clock_out;
		end
		else
			half_cnt <= half_cnt + 1;
	end

	// uart line held low for a number of mclk cycles
	task hold_tx_low(input int unsigned mclks);
		@(posedge mclk_in);
		serial_tx_out <= 1'b0;
		repeat (mclks) @(posedge mclk_in);
		serial_tx_out <= 1'b1;
	endtask : hold_tx_low

	// fast falling edges, two cycles low and two high each
	task tx_burst(input int unsigned cnt);
		repeat (cnt)
		begin
			@(posedge mclk_in);
			serial_tx_out <= 1'b0;
			repeat (2) @(posedge mclk_in);
			serial_tx_out <= 1'b1;
			@(posedge mclk_in);
		end
	endtask : tx_burst

	// one light pulse from the optical receiver
	task light_pulse(input int unsigned mclks);
		@(posedge mclk_in);
		optical_rx_out <= 1'b1;
		repeat (mclks) @(posedge mclk_in);
		optical_rx_out <= 1'b0;
	endtask : light_pulse
endmodule : ircd_far_end

/* testbench/testbench.sv */
// Purpose: self-checking bench for the infrared pulse codec
// Assumes: crystal divider cut to 4, external x16 period 12 mclks
// Notes: pulse widths allow one tick period short and one mclk long for tick alignment
`timescale 1ns/10ps
module testbench;
	localparam int X16 = 12;
	localparam int XTAL = 4;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic codec_reset_low = 1'b1;
	logic sel = 1'b0;
	logic sleep = 1'b0;
	logic fixed = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic x16, stx, orx, otx, srx, oscp, acc, wreq, acc_low;
	logic [31:0] rdata;
	logic [31:0] q;
	logic mon_clr = 1'b0;
	logic act [2];
	int n [2];
	int lo [2];
	int hi [2];
	int run [2];
	int fails = 0;
	int tests_run = 0;

	always #2.5 mclk_in = ~mclk_in;

	ircd_codec #(.CRYSTAL_DIV(XTAL), .FIFO_DEPTH(4)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.codec_reset_low_in(codec_reset_low), .clock_source_select_in(sel),
		.osc_sleep_request_in(sleep), .fixed_pulse_select_in(fixed),
		.baud_x16_clock_in(x16), .serial_tx_in(stx), .optical_rx_in(orx),
		.optical_tx_out(otx), .serial_rx_out(srx), .osc_powered_out(oscp),
		.tx_accept_out(acc), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq));

	ircd_far_end #(.X16_HALF(X16 / 2)) far (.mclk_in(mclk_in), .baud_x16_clock_out(x16),
		.serial_tx_out(stx), .optical_rx_out(orx));

	// pulse monitor: index 0 optical tx high, index 1 serial rx low
	always @(posedge mclk_in)
	begin
		act[0] = otx;
		act[1] = !srx;
		if (mon_clr)
			acc_low = 1'b0;
		else if (acc === 1'b0)
			acc_low = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			if (mon_clr)
			begin
				n[i] = 0;
				lo[i] = 9999;
				hi[i] = 0;
				run[i] = 0;
			end
			else if (act[i] === 1'b1)
				run[i]++;
			else if (run[i] > 0)
			begin
				n[i]++;
				lo[i] = (run[i] < lo[i]) ? run[i] : lo[i];
				hi[i] = (run[i] > hi[i]) ? run[i] : hi[i];
				run[i] = 0;
			end
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task check_in(input int got, input int lo_b, input int hi_b);
		tests_run++;
		if (got < lo_b || got > hi_b)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo_b, hi_b);
		end
	endtask : check_in

	// one avalon transfer; request held until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		int k;
		k = 0;
		@(posedge mclk_in);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= b;
		do
		begin
			@(posedge mclk_in);
			k++;
		end
		while (wreq !== 1'b0 && k < 50);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 50)
		begin
			fails++;
			test_done();
		end
	endtask : bus

	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		check(q, exp);
	endtask : rd_chk

	task clear;
		@(posedge mclk_in);
		mon_clr <= 1'b1;
		@(posedge mclk_in);
		mon_clr <= 1'b0;
	endtask : clear

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// reset values, refused writes, second reset mid-run
	task t_regs;
		rd_chk(ircd_pkg::REG_CTRL, 32'h3);
		rd_chk(4'hc, 32'h0);
		bus(1'b1, 4'hc, 32'hffffffff, 4'hf);
		bus(1'b1, ircd_pkg::REG_CTRL, 32'h0, 4'h0);
		rd_chk(ircd_pkg::REG_CTRL, 32'h3);
		bus(1'b1, ircd_pkg::REG_CTRL, 32'h0, 4'hf);
		rd_chk(ircd_pkg::REG_CTRL, 32'h0);
		@(posedge mclk_in);
		rst_in <= 1'b1;
		@(posedge mclk_in);
		rst_in <= 1'b0;
		rd_chk(ircd_pkg::REG_CTRL, 32'h3);
		rd_chk(ircd_pkg::REG_RX_COUNT, 32'h0);
		$display("test regs done");
	endtask : t_regs

	// every select and sleep combination
	task t_osc;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge mclk_in);
			sel <= i[0];
			sleep <= i[1];
			@(posedge mclk_in);
			@(negedge mclk_in);
			check({31'h0, oscp}, {31'h0, !(i[0] | i[1])});
			rd_chk(ircd_pkg::REG_STATUS, {30'h4, i[0], !(i[0] | i[1])});
		end
		sel <= 1'b0;
		sleep <= 1'b0;
		$display("test osc done");
	endtask : t_osc

	// long low stretch of 40 external x16 periods, count and width of pulses
	task t_tx(input logic s, input logic f, input int exp_n, input int lo_b, input int hi_b);
		@(posedge mclk_in);
		sel <= s;
		fixed <= f;
		clear();
		far.hold_tx_low(40 * X16);
		repeat (16 * X16) @(posedge mclk_in);
		check(n[0], exp_n);
		check_in(lo[0], lo_b, hi_b);
		check_in(hi[0], lo_b, hi_b);
		$display("test tx done");
	endtask : t_tx

	// monoshot queue filled past its depth, then drained
	task t_fill;
		int k;
		@(posedge mclk_in);
		fixed <= 1'b1;
		clear();
		far.tx_burst(6);
		check({31'h0, acc_low}, 32'h1);
		k = 0;
		// poll until the queue drains, then judge the final status once
		do
		begin
			bus(1'b0, ircd_pkg::REG_STATUS, 32'h0, 4'hf);
			k++;
		end
		while (q !== 32'h1d && k < 100);
		check(q, 32'h1d);
		if (q !== 32'h1d)
			test_done();
		repeat (6 * XTAL + 4) @(posedge mclk_in);
		check(n[0], 5);
		bus(1'b1, ircd_pkg::REG_STATUS, 32'h8, 4'hf);
		rd_chk(ircd_pkg::REG_STATUS, 32'h15);
		fixed <= 1'b0;
		$display("test fill done");
	endtask : t_fill

	// proportional and short pulses decoded, then rx disabled
	task t_rx;
		@(posedge mclk_in);
		sel <= 1'b1;
		clear();
		far.light_pulse(3 * X16);
		repeat (20 * X16) @(posedge mclk_in);
		far.light_pulse(2);
		repeat (20 * X16) @(posedge mclk_in);
		check(n[1], 2);
		check_in(lo[1], 15 * X16, 16 * X16 + 1);
		check_in(hi[1], 15 * X16, 16 * X16 + 1);
		rd_chk(ircd_pkg::REG_RX_COUNT, 32'h2);
		bus(1'b1, ircd_pkg::REG_CTRL, 32'h1, 4'hf);
		clear();
		far.light_pulse(3 * X16);
		repeat (20 * X16) @(posedge mclk_in);
		check(n[1], 0);
		rd_chk(ircd_pkg::REG_RX_COUNT, 32'h2);
		bus(1'b1, ircd_pkg::REG_CTRL, 32'h3, 4'hf);
		$display("test rx done");
	endtask : t_rx

	// codec reset cuts a decoded bit short and blocks both paths
	task t_hold;
		far.light_pulse(3 * X16);
		codec_reset_low <= 1'b0;
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
		check({31'h0, srx}, 32'h1);
		clear();
		far.light_pulse(3 * X16);
		far.hold_tx_low(40 * X16);
		repeat (16 * X16) @(posedge mclk_in);
		check(n[0], 0);
		check(n[1], 0);
		rd_chk(ircd_pkg::REG_RX_COUNT, 32'h3);
		codec_reset_low <= 1'b1;
		$display("test hold done");
	endtask : t_hold

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_regs();
		t_osc();
		t_tx(1'b1, 1'b0, 3, 2 * X16, 3 * X16 + 1);
		t_tx(1'b0, 1'b0, 4, 2 * 2 * XTAL, 3 * 2 * XTAL + 1);
		t_tx(1'b0, 1'b1, 1, 5 * XTAL, 6 * XTAL + 1);
		t_fill();
		t_rx();
		t_hold();
		test_done();
	end
endmodule : testbench
